// ### hdl/cwts_sequencer.sv
/*
  Channel word transfer sequencer: storage-to-storage copy alternation, output word buffering with
  demand-sync hand-over to the assembly register, input word assembly, and a two-entry character buffer.
  Assumes all inputs are synchronous to mclk_i, storage read data valid the cycle after a grant,
  and a grant pulse standing for both priority and storage time.
*/
`timescale 1ns/100ps

// Summary of operation
// - Even copy cycle, nonzero count: write, fetch word.
// - Even copy cycle, zero count: fetch next command.
// - Odd copy cycle: read status, store via address.
// - Even data cycle loads buffer, steps command counter.
// - Odd data cycle stores buffer, counts word down.
// - Write status means out of storage; read into.
// - Output word goes buffer, assembly, characters out.
// - Input characters fill assembly, then move to buffer.
// - Each service request answered by service response.
// - Control orders write and hold till end; copies write only after control-write.
// - Control-write then copy sets sticky write trigger.
// - Loaded flag tracks unconsumed buffer word.
// - Unloaded and nonzero count requests a storage cycle.
// - Clear buffer, sample bus, set loaded, step counters.
// - No new request until word reaches assembly.
// - Demand-sync from write start, then ring six.
// - Demand-sync copies buffer, clears loaded, requests again.
// - Buffer kept until next data storage cycle start.
// - Repeat fetch and hand-over until end.
// - Write start moves ring six to one.
// - Zero initial copy count skips the command.
module cwts_sequencer
  import cwts_pkg::*;
(
  input  wire logic                    mclk_i,             // System clock, 100 MHz.
  input  wire logic                    rst_i,              // Asynchronous reset, active high.
  input  wire logic                    cmd_start_i,        // One-cycle pulse: start the command below.
  input  wire cwts_cmd_t               cmd_kind_i,         // Command code.
  input  wire logic [CWTS_ADDR_W-1:0]  cmd_counter_i,      // Command counter load value.
  input  wire logic [CWTS_ADDR_W-1:0]  cmd_address_i,      // Address counter load value.
  input  wire logic [CWTS_COUNT_W-1:0] cmd_count_i,        // Word counter load value.
  input  wire logic                    end_i,              // One-cycle pulse: normal or abnormal end.
  input  wire logic                    stg_grant_i,        // Priority and storage time granted.
  input  wire logic [CWTS_WORD_W-1:0]  stg_rdata_i,        // Storage bus read data.
  input  wire logic                    write_start_i,      // Write start pulse for the first word.
  input  wire logic                    disconnect_i,       // Level: no further demand-sync.
  input  wire logic                    service_request_i,  // Adapter service request level.
  input  wire logic [CWTS_CHAR_W-1:0]  char_in_i,          // Incoming character.
  input  wire logic                    char_ready_i,       // Character consumer ready.
  output logic                         stg_req_o,          // Storage cycle request.
  output logic                         stg_fetch_o,        // Request is a command fetch.
  output logic                         stg_we_o,           // One-cycle store strobe.
  output logic [CWTS_WORD_W-1:0]       stg_wdata_o,        // Store data.
  output logic [CWTS_ADDR_W-1:0]       mem_addr_o,         // Memory address latch.
  output logic                         write_status_o,     // Data moving out of storage.
  output logic                         read_status_o,      // Data moving into storage.
  output logic                         loaded_o,           // Word buffer holds an unconsumed word.
  output logic [CWTS_COUNT_W-1:0]      word_count_o,       // Word counter.
  output logic [CWTS_RING_W-1:0]       ring_o,             // Assembly ring position.
  output logic [CWTS_WORD_W-1:0]       assembly_o,         // Assembly register.
  output logic                         service_response_o, // One-cycle service response.
  output logic [CWTS_CHAR_W-1:0]       char_o,             // Outgoing character.
  output logic                         char_valid_o,       // Outgoing character valid.
  output logic                         cmd_done_o          // One-cycle pulse: command finished.
);

  typedef struct packed {
    cwts_state_t               state;
    logic                      alternate;
    logic                      write_status;
    logic                      read_status;
    logic                      control_gate;
    logic                      write_trigger;
    logic                      control_write_seen;
    logic                      req;
    logic                      fetch;
    logic                      we;
    logic                      phase;
    logic [CWTS_ADDR_W-1:0]    command_counter;
    logic [CWTS_ADDR_W-1:0]    address_counter;
    logic [CWTS_COUNT_W-1:0]   word_counter;
    logic [CWTS_ADDR_W-1:0]    memory_address_latch;
    logic [CWTS_WORD_W-1:0]    word_buffer;
    logic [CWTS_WORD_W-1:0]    assembly;
    logic                      loaded;
    logic [CWTS_RING_W-1:0]    ring;
    logic                      request_seen;
    logic                      pending;
    logic                      response;
    logic [CWTS_CHAR_W-1:0]    head;
    logic [CWTS_CHAR_W-1:0]    tail;
    logic                      head_valid;
    logic                      tail_valid;
    logic                      done;
  } cwts_reg_t;

  cwts_reg_t s;
  cwts_reg_t next_s;

  // Next-state logic for the whole sequencer.
  always_comb begin
    logic [CWTS_RING_W-1:0] pos;
    logic [CWTS_CHAR_W-1:0] outc;
    pos    = s.ring;
    outc   = '0;
    next_s = s;
    next_s.response = 1'b0;
    next_s.done     = 1'b0;
    next_s.we       = 1'b0;

    // The consumer drains the buffer head; the tail shifts forward.
    if (s.head_valid && char_ready_i) begin
      next_s.head       = s.tail;
      next_s.head_valid = s.tail_valid;
      next_s.tail_valid = 1'b0;
    end

    // A rising service request is held until the buffer has room.
    if (service_request_i && !s.request_seen) begin
      next_s.pending = 1'b1;
    end
    next_s.request_seen = service_request_i;

    case (s.state)
      ST_IDLE: begin
        if (cmd_start_i) begin
          next_s.command_counter = cmd_counter_i;
          next_s.address_counter = cmd_address_i;
          next_s.word_counter    = cmd_count_i;
          next_s.alternate       = 1'b0;
          next_s.loaded          = 1'b0;
          next_s.ring            = CWTS_RING_LAST;
          case (cmd_kind_i)
            CMD_STORAGE_COPY: begin
              if (cmd_count_i == CWTS_COUNT_ZERO) begin
                next_s.req                  = 1'b1;
                next_s.fetch                = 1'b1;
                next_s.memory_address_latch = cmd_counter_i;
                next_s.state                = ST_COMMAND_FETCH;
              end else begin
                next_s.state = ST_COMMAND_CYCLE;
              end
            end
            CMD_CONTROL_ORDER, CMD_CONTROL_THEN_WRITE, CMD_CONTROL_THEN_READ: begin
              next_s.control_gate       = 1'b1;
              next_s.write_status       = 1'b1;
              next_s.read_status        = 1'b0;
              next_s.control_write_seen = (cmd_kind_i == CMD_CONTROL_THEN_WRITE);
              next_s.state              = ST_STREAM;
            end
            CMD_SENSE: begin
              next_s.write_status = 1'b0;
              next_s.read_status  = 1'b1;
              next_s.state        = ST_STREAM;
            end
            CMD_COPY_PROCEED, CMD_COPY_DISCONNECT: begin
              if (s.control_write_seen) begin
                next_s.write_trigger = 1'b1;
                next_s.write_status  = 1'b1;
                next_s.read_status   = 1'b0;
              end
              next_s.state = ST_STREAM;
            end
            default: begin
              next_s.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_COMMAND_CYCLE: begin
        if (!s.alternate) begin
          if (s.word_counter != CWTS_COUNT_ZERO) begin
            next_s.alternate            = 1'b1;
            next_s.write_status         = 1'b1;
            next_s.read_status          = 1'b0;
            next_s.req                  = 1'b1;
            next_s.fetch                = 1'b0;
            next_s.memory_address_latch = s.command_counter;
            next_s.state                = ST_DATA_WORD;
          end else begin
            next_s.req                  = 1'b1;
            next_s.fetch                = 1'b1;
            next_s.memory_address_latch = s.command_counter;
            next_s.state                = ST_COMMAND_FETCH;
          end
        end else begin
          next_s.alternate            = 1'b0;
          next_s.write_status         = 1'b0;
          next_s.read_status          = 1'b1;
          next_s.req                  = 1'b1;
          next_s.fetch                = 1'b0;
          next_s.memory_address_latch = s.address_counter;
          next_s.state                = ST_DATA_WORD;
        end
      end
      ST_DATA_WORD: begin
        if (s.phase) begin
          next_s.word_buffer     = stg_rdata_i;
          next_s.command_counter = s.command_counter + CWTS_ADDR_STEP;
          next_s.phase           = 1'b0;
          next_s.state           = ST_COMMAND_CYCLE;
        end else if (s.req && stg_grant_i) begin
          next_s.req = 1'b0;
          if (s.alternate) begin
            next_s.word_buffer = '0;
            next_s.phase       = 1'b1;
          end else begin
            next_s.we           = 1'b1;
            next_s.word_counter = s.word_counter - CWTS_COUNT_STEP;
            next_s.state        = ST_ADDR_STEP;
          end
        end
      end
      ST_ADDR_STEP: begin
        next_s.address_counter = s.address_counter + CWTS_ADDR_STEP;
        next_s.state           = ST_COMMAND_CYCLE;
      end
      ST_COMMAND_FETCH: begin
        if (s.req && stg_grant_i) begin
          next_s.req          = 1'b0;
          next_s.fetch        = 1'b0;
          next_s.write_status = 1'b0;
          next_s.read_status  = 1'b0;
          next_s.done         = 1'b1;
          next_s.state        = ST_IDLE;
        end
      end
      ST_STREAM: begin
        if (s.write_status) begin
          // Output fetch: request whenever the buffer is empty and words remain.
          if (s.phase) begin
            next_s.word_buffer     = stg_rdata_i;
            next_s.loaded          = 1'b1;
            next_s.word_counter    = s.word_counter - CWTS_COUNT_STEP;
            next_s.address_counter = s.address_counter + CWTS_ADDR_STEP;
            next_s.phase           = 1'b0;
          end else if (s.req && stg_grant_i) begin
            next_s.req         = 1'b0;
            next_s.word_buffer = '0;
            next_s.phase       = 1'b1;
          end else if (!s.loaded && !s.req && s.word_counter != CWTS_COUNT_ZERO) begin
            next_s.req                  = 1'b1;
            next_s.fetch                = 1'b0;
            next_s.memory_address_latch = s.address_counter;
          end
          if (write_start_i && s.ring == CWTS_RING_LAST) begin
            next_s.ring     = CWTS_RING_FIRST;
            next_s.assembly = s.word_buffer;
            next_s.loaded   = 1'b0;
          end else if (s.pending && !next_s.tail_valid) begin
            outc            = s.assembly[(CWTS_CHARS - int'(s.ring)) * CWTS_CHAR_W +: CWTS_CHAR_W];
            next_s.pending  = service_request_i && !s.request_seen; // A new edge wins over the clear.
            next_s.response = 1'b1;
            if (s.ring == CWTS_RING_LAST) begin
              if (s.loaded && !disconnect_i) begin
                next_s.assembly = s.word_buffer;
                next_s.loaded   = 1'b0;
                next_s.ring     = CWTS_RING_FIRST;
              end
            end else begin
              next_s.ring = s.ring + CWTS_RING_FIRST;
            end
            if (!next_s.head_valid) begin
              next_s.head       = outc;
              next_s.head_valid = 1'b1;
            end else begin
              next_s.tail       = outc;
              next_s.tail_valid = 1'b1;
            end
          end
        end else if (s.read_status) begin
          // Input: store the assembled word when storage is granted.
          if (s.req && stg_grant_i) begin
            next_s.req             = 1'b0;
            next_s.we              = 1'b1;
            next_s.loaded          = 1'b0;
            next_s.address_counter = s.address_counter + CWTS_ADDR_STEP;
          end
          if (s.pending) begin
            pos             = (s.ring == CWTS_RING_LAST) ? CWTS_RING_FIRST : s.ring + CWTS_RING_FIRST;
            next_s.assembly[(CWTS_CHARS - int'(pos)) * CWTS_CHAR_W +: CWTS_CHAR_W] = char_in_i;
            next_s.ring     = pos;
            next_s.pending  = service_request_i && !s.request_seen; // A new edge wins over the clear.
            next_s.response = 1'b1;
            if (pos == CWTS_RING_LAST && !s.loaded) begin
              next_s.word_buffer          = next_s.assembly;
              next_s.loaded               = 1'b1;
              next_s.req                  = 1'b1;
              next_s.fetch                = 1'b0;
              next_s.memory_address_latch = s.address_counter;
            end
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // An end during streaming releases every status and returns to rest.
    if (end_i && s.state == ST_STREAM) begin
      next_s.write_status       = 1'b0;
      next_s.read_status        = 1'b0;
      next_s.control_gate       = 1'b0;
      next_s.write_trigger      = 1'b0;
      next_s.control_write_seen = next_s.control_write_seen && s.control_gate;
      next_s.req                = 1'b0;
      next_s.phase              = 1'b0;
      next_s.done               = 1'b1;
      next_s.state              = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s       <= '0;
      s.state <= ST_IDLE;
      s.ring  <= CWTS_RING_LAST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs taken straight from the state register.
  assign stg_req_o          = s.req;
  assign stg_fetch_o        = s.fetch;
  assign stg_we_o           = s.we;
  assign stg_wdata_o        = s.word_buffer;
  assign mem_addr_o         = s.memory_address_latch;
  assign write_status_o     = s.write_status;
  assign read_status_o      = s.read_status;
  assign loaded_o           = s.loaded;
  assign word_count_o       = s.word_counter;
  assign ring_o             = s.ring;
  assign assembly_o         = s.assembly;
  assign service_response_o = s.response;
  assign char_o             = s.head;
  assign char_valid_o       = s.head_valid;
  assign cmd_done_o         = s.done;

endmodule // cwts_sequencer

// ### hdl/cwts_pkg.sv
/*
  Shared constants and types for the channel word transfer sequencer.
  Assumes a single 100 MHz clock domain and a host storage port that grants one cycle at a time.
*/
package cwts_pkg;

  // Data path geometry.
  localparam int CWTS_ADDR_W  = 15;
  localparam int CWTS_COUNT_W = 15;
  localparam int CWTS_WORD_W  = 36;
  localparam int CWTS_CHAR_W  = 6;
  localparam int CWTS_CHARS   = 6;
  localparam int CWTS_RING_W  = 3;

  // Assembly ring positions; the ring rests at the last slot.
  localparam logic [CWTS_RING_W-1:0] CWTS_RING_FIRST = 3'h1;
  localparam logic [CWTS_RING_W-1:0] CWTS_RING_LAST  = 3'h6;

  // Counter step and the zero count.
  localparam logic [CWTS_ADDR_W-1:0]  CWTS_ADDR_STEP  = 15'h0001;
  localparam logic [CWTS_COUNT_W-1:0] CWTS_COUNT_STEP = 15'h0001;
  localparam logic [CWTS_COUNT_W-1:0] CWTS_COUNT_ZERO = 15'h0000;

  // Command codes presented with a command start.
  typedef enum logic [2:0] {
    CMD_STORAGE_COPY      = 3'h0,
    CMD_CONTROL_ORDER     = 3'h1,
    CMD_CONTROL_THEN_WRITE = 3'h2,
    CMD_CONTROL_THEN_READ = 3'h3,
    CMD_SENSE             = 3'h4,
    CMD_COPY_PROCEED      = 3'h5,
    CMD_COPY_DISCONNECT   = 3'h6,
    CMD_NONE              = 3'h7
  } cwts_cmd_t;

  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE          = 6'h01,
    ST_COMMAND_CYCLE = 6'h02,
    ST_DATA_WORD     = 6'h04,
    ST_ADDR_STEP     = 6'h08,
    ST_COMMAND_FETCH = 6'h10,
    ST_STREAM        = 6'h20
  } cwts_state_t;

endpackage : cwts_pkg

// ### bench/cwts_seq_asserts.sv
/*
  Port checks for the sequencer: storage handshake, status, ring, counting and hand-over.
  Assumes it is bound onto cwts_sequencer and runs in the single mclk_i domain.
*/
`timescale 1ns/100ps
module cwts_seq_asserts
  import cwts_pkg::*;
(
  input wire logic                    mclk_i,            // Clock.
  input wire logic                    rst_i,             // Reset.
  input wire logic                    cmd_start_i,       // Start.
  input wire logic                    stg_grant_i,       // Grant.
  input wire logic                    write_start_i,     // Write start.
  input wire logic                    stg_req_o,         // Request.
  input wire logic                    stg_fetch_o,       // Fetch kind.
  input wire logic                    stg_we_o,          // Store strobe.
  input wire logic [CWTS_ADDR_W-1:0]  mem_addr_o,        // Address.
  input wire logic                    write_status_o,    // Write status.
  input wire logic                    read_status_o,     // Read status.
  input wire logic                    loaded_o,          // Loaded.
  input wire logic [CWTS_COUNT_W-1:0] word_count_o,      // Count.
  input wire logic [CWTS_RING_W-1:0]  ring_o,            // Ring.
  input wire logic                    service_response_o // Response.
);
  // All checks share one clock and the reset.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // A request and what qualifies it stand until granted.
  req_stands_a: assert property (stg_req_o && !stg_grant_i |=> stg_req_o && $stable(mem_addr_o) && $stable(stg_fetch_o))
    else $error("request dropped or changed before grant");
  status_excl_a: assert property (!(write_status_o && read_status_o))
    else $error("write and read status together");
  store_read_a: assert property (stg_we_o |-> read_status_o && $past(stg_grant_i && stg_req_o))
    else $error("store strobe without read status or grant");
  ring_range_a: assert property (ring_o >= 3'h1 && ring_o <= 3'h6)
    else $error("ring out of range");
  ring_wrap_a: assert property ($past(ring_o) == 3'h6 && ring_o != 3'h6 |-> ring_o == 3'h1)
    else $error("ring left six for other than one");
  handover_a: assert property (write_start_i && ring_o == 3'h6 && write_status_o && loaded_o
    |=> ring_o == 3'h1 && !loaded_o)
    else $error("write start did not hand the word over");
  rerequest_a: assert property ($fell(loaded_o) && write_status_o && word_count_o != 15'h0000 |-> ##[0:2] stg_req_o)
    else $error("no request after hand-over");
  count_step_a: assert property ($changed(word_count_o) && !$past(cmd_start_i)
    |-> word_count_o == $past(word_count_o) - 15'h0001)
    else $error("word count moved by other than one");
  resp_pulse_a: assert property (service_response_o |=> !service_response_o)
    else $error("service response longer than one cycle");
endmodule // cwts_seq_asserts

// ### bench/cwts_storage_model.sv
/*
  Core storage behind the grant: sixteen words, grant after a set delay, data the cycle after.
  Assumes the sequencer holds its request until granted.
*/
`timescale 1ns/100ps
module cwts_storage_model
  import cwts_pkg::*;
(
  input  wire logic                   mclk_i,    // Clock.
  input  wire logic                   rst_i,     // Reset.
  input  wire logic                   stg_req_i, // Request.
  input  wire logic                   stg_we_i,  // Store strobe.
  input  wire logic [CWTS_ADDR_W-1:0] addr_i,    // Address.
  input  wire logic [CWTS_WORD_W-1:0] wdata_i,   // Store data.
  input  wire logic [3:0]             delay_i,   // Grant delay.
  output logic                        grant_o,   // Grant pulse.
  output logic [CWTS_WORD_W-1:0]      rdata_o    // Read data.
);
  logic [CWTS_WORD_W-1:0] mem [0:15];
  logic [3:0]             wait_cnt;
  logic [CWTS_ADDR_W-1:0] addr_q;

  // Each word holds a pattern plus its own address.
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 36'h2c5a3e000 + 36'(i);
  end

  // Grant after the delay; read data lives one cycle, then toggles so stale data never passes.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_o  <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o  <= 36'h000000000;
      addr_q   <= 15'h0000;
    end else begin
      grant_o  <= stg_req_i && !grant_o && wait_cnt == delay_i;
      wait_cnt <= (stg_req_i && !grant_o && wait_cnt != delay_i) ? wait_cnt + 4'h1 : 4'h0;
      if (grant_o && stg_req_i) begin
        addr_q  <= addr_i;
        rdata_o <= mem[addr_i[3:0]];
      end else begin
        rdata_o <= ~rdata_o;
      end
      if (stg_we_i) mem[addr_q[3:0]] <= wdata_i;
    end
  end
endmodule // cwts_storage_model

// ### bench/cwts_sequencer_tb_top.sv
/*
  Self-checking bench: storage copy, zero-count skip and output streaming with hand-over.
  Assumes the storage model answers requests and the bench plays the adapter.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module cwts_sequencer_tb_top;
  import cwts_pkg::*;
  logic                    mclk_i, rst_i, cmd_start_i, end_i, stg_grant_i, write_start_i, disconnect_i;
  logic                    service_request_i, char_ready_i, stg_req_o, stg_fetch_o, stg_we_o;
  logic                    write_status_o, read_status_o, loaded_o, service_response_o, char_valid_o, cmd_done_o;
  cwts_cmd_t               cmd_kind_i;
  logic [CWTS_ADDR_W-1:0]  cmd_counter_i, cmd_address_i, mem_addr_o;
  logic [CWTS_COUNT_W-1:0] cmd_count_i, word_count_o;
  logic [CWTS_WORD_W-1:0]  stg_rdata_i, stg_wdata_o, assembly_o;
  logic [CWTS_CHAR_W-1:0]  char_in_i, char_o;
  logic [CWTS_RING_W-1:0]  ring_o;
  logic [3:0]              delay;
  int                      err_count, tests_run, cycles;

  cwts_sequencer dut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_start_i(cmd_start_i), .cmd_kind_i(cmd_kind_i),
    .cmd_counter_i(cmd_counter_i), .cmd_address_i(cmd_address_i), .cmd_count_i(cmd_count_i), .end_i(end_i),
    .stg_grant_i(stg_grant_i), .stg_rdata_i(stg_rdata_i), .write_start_i(write_start_i),
    .disconnect_i(disconnect_i), .service_request_i(service_request_i), .char_in_i(char_in_i),
    .char_ready_i(char_ready_i), .stg_req_o(stg_req_o), .stg_fetch_o(stg_fetch_o), .stg_we_o(stg_we_o),
    .stg_wdata_o(stg_wdata_o), .mem_addr_o(mem_addr_o), .write_status_o(write_status_o),
    .read_status_o(read_status_o), .loaded_o(loaded_o), .word_count_o(word_count_o), .ring_o(ring_o),
    .assembly_o(assembly_o), .service_response_o(service_response_o), .char_o(char_o),
    .char_valid_o(char_valid_o), .cmd_done_o(cmd_done_o));
  cwts_storage_model model (.mclk_i(mclk_i), .rst_i(rst_i), .stg_req_i(stg_req_o), .stg_we_i(stg_we_o),
    .addr_i(mem_addr_o), .wdata_i(stg_wdata_o), .delay_i(delay), .grant_o(stg_grant_i), .rdata_o(stg_rdata_i));

  // Clock and a hang limit well above the hundred or so cycles the tests need.
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Inputs change one time unit after the rising edge.
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  function automatic logic [CWTS_WORD_W-1:0] word_at(int a);
    return 36'h2c5a3e000 + 36'(a);
  endfunction

  task automatic start_cmd(cwts_cmd_t k, int cc, int ac, int cnt);
    cmd_kind_i = k;
    cmd_counter_i = 15'(cc);
    cmd_address_i = 15'(ac);
    cmd_count_i = 15'(cnt);
    cmd_start_i = 1'b1;
    tick();
    cmd_start_i = 1'b0;
  endtask

  // Waits for the next storage request, judges it, then waits for its grant.
  task automatic expect_req(string n, logic f, logic w, int a);
    for (int i = 0; i < 100 && stg_req_o !== 1'b1; i++) tick();
    `CHK(n, {1'b1, f, 15'(a)}, {stg_req_o, stg_fetch_o, mem_addr_o})
    if (!f) `CHK(n, {w, !w}, {write_status_o, read_status_o})
    for (int i = 0; i < 100 && stg_req_o === 1'b1; i++) tick();
  endtask

  task automatic wait_done();
    for (int i = 0; i < 200 && cmd_done_o !== 1'b1; i++) tick();
    `CHK("done", 1'b1, cmd_done_o)
    tick();
  endtask

  // One adapter request; the character and the response must both come back.
  task automatic serve_char(logic [CWTS_CHAR_W-1:0] exp);
    logic                   resp;
    logic [CWTS_CHAR_W-1:0] got;
    resp = 1'b0;
    got = ~exp;
    service_request_i = 1'b1;
    for (int i = 0; i < 20 && !(resp && got === exp); i++) begin
      tick();
      if (char_valid_o === 1'b1) got = char_o;
      if (service_response_o === 1'b1) resp = 1'b1;
    end
    `CHK("char", {1'b1, exp}, {resp, got})
    service_request_i = 1'b0;
    tick(2);
  endtask

  // Two-word copy with a slow grant: alternation, addresses and stored words.
  task automatic copy_two();
    delay = 4'h3;
    start_cmd(CMD_STORAGE_COPY, 3, 8, 2);
    expect_req("copy in 0", 1'b0, 1'b1, 3);
    expect_req("copy out 0", 1'b0, 1'b0, 8);
    expect_req("copy in 1", 1'b0, 1'b1, 4);
    expect_req("copy out 1", 1'b0, 1'b0, 9);
    expect_req("copy next", 1'b1, 1'b0, 5);
    wait_done();
    `CHK("copy word 0", word_at(3), model.mem[8])
    `CHK("copy word 1", word_at(4), model.mem[9])
    `CHK("copy count", 15'h0000, word_count_o)
  endtask

  // Zero count: straight to the next command, assembly and storage untouched.
  task automatic copy_zero();
    logic [CWTS_WORD_W-1:0] held;
    held = assembly_o;
    delay = 4'h0;
    start_cmd(CMD_STORAGE_COPY, 6, 10, 0);
    expect_req("skip fetch", 1'b1, 1'b0, 6);
    wait_done();
    `CHK("skip assembly", held, assembly_o)
    `CHK("skip storage", word_at(10), model.mem[10])
  endtask

  // Control-then-write, then a copy streaming one word and the next word's first character out character by character.
  task automatic stream_out();
    logic [CWTS_WORD_W-1:0] w4;
    logic [CWTS_WORD_W-1:0] w5;
    w4 = word_at(4);
    w5 = word_at(5);
    delay = 4'h1;
    start_cmd(CMD_CONTROL_THEN_WRITE, 0, 0, 0);
    tick(2);
    `CHK("order write", 1'b1, write_status_o)
    end_i = 1'b1;
    tick();
    end_i = 1'b0;
    wait_done();
    start_cmd(CMD_COPY_PROCEED, 0, 4, 2);
    expect_req("out word 0", 1'b0, 1'b1, 4);
    tick(4);
    `CHK("out loaded", {1'b1, 15'h0001, 1'b0}, {loaded_o, word_count_o, stg_req_o})
    write_start_i = 1'b1;
    tick();
    write_start_i = 1'b0;
    `CHK("out handover", {3'h1, w4, w4}, {ring_o, assembly_o, stg_wdata_o})
    expect_req("out word 1", 1'b0, 1'b1, 5);
    for (int k = 0; k < 7; k++) serve_char(k < 6 ? w4[35-6*k -: 6] : w5[35:30]);
    tick(4);
    `CHK("out second", {w5, 1'b0}, {assembly_o, stg_req_o})
    end_i = 1'b1;
    tick();
    end_i = 1'b0;
    wait_done();
  endtask

  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    rst_i = 1'b1;
    {cmd_start_i, end_i, write_start_i, disconnect_i, service_request_i} = 5'h00;
    cmd_kind_i = CMD_NONE;
    {cmd_counter_i, cmd_address_i, cmd_count_i} = 45'h0;
    char_in_i = 6'h00;
    char_ready_i = 1'b1;
    delay = 4'h0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    tick(16);
    rst_i = 1'b0;
    `CHK("reset ring", 3'h6, ring_o)
    copy_two();
    copy_zero();
    stream_out();
    complete_run();
  end
endmodule // cwts_sequencer_tb_top

bind cwts_sequencer cwts_seq_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_start_i(cmd_start_i),
  .stg_grant_i(stg_grant_i), .write_start_i(write_start_i), .stg_req_o(stg_req_o), .stg_fetch_o(stg_fetch_o),
  .stg_we_o(stg_we_o), .mem_addr_o(mem_addr_o), .write_status_o(write_status_o), .read_status_o(read_status_o),
  .loaded_o(loaded_o), .word_count_o(word_count_o), .ring_o(ring_o), .service_response_o(service_response_o));
